// >>> bench/gcs_fet_model.sv
/*
 behavioural model of six power switch gates with their comparators.
 assumes gate levels from gcs_top and a bench that sets the charge time.
*/
`timescale 1ns/10ps
module gcs_fet_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [5:0] gate,
    input wire logic [15:0] trip_after,
    input wire logic [5:0] noise,
    output logic [5:0] cmp
);
    logic [5:0] last;
    logic [5:0] reached;
    logic [15:0] cnt [6];
    // gate reaches its target a fixed time after each change
    always_ff @(posedge aclk) begin
        for (int g = 0; g < 6; g++) begin
            if (!aresetn || gate[g] != last[g]) begin
                cnt[g] <= 16'h0000;
                reached[g] <= 1'b0;
            end else if (cnt[g] >= trip_after) begin
                reached[g] <= 1'b1;
            end else begin
                cnt[g] <= cnt[g] + 16'h0001;
            end
        end
        last <= gate;
    end
    assign cmp = reached | noise;
endmodule

// >>> bench/testbench.sv
/*
 self-checking bench: register access, gate current phases, trips.
 assumes gcs_fet_model stands at the gate outputs.
*/
`timescale 1ns/10ps
module testbench
    import gcs_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic [5:0] gate_cmd = 6'h00;
    logic [5:0] vgs_cmp;
    logic [5:0] gate_out;
    logic [17:0] gate_sel;
    logic [29:0] gate_code;
    logic [15:0] trip_after = 16'hffff;
    logic [5:0] noise = 6'h00;
    int fail_count = 0;
    int checks_done = 0;
    logic [2:0] run_sel [8];
    logic [4:0] run_code [8];
    int run_len [8];
    int nruns;
    logic [7:0] tm [4];
    always #10 aclk = ~aclk;
    gcs_top gcs_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gate_cmd, .vgs_cmp,
        .gate_out, .gate_sel, .gate_code);
    gcs_fet_model gcs_fet_model_inst (.aclk, .aresetn, .gate(gate_out),
        .trip_after, .noise, .cmp(vgs_cmp));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic complete_run();
        if (fail_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 200);
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
        if (n >= 200) fail_count++;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 200);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
        if (n >= 200) fail_count++;
    endtask
    task automatic reg_chk(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] r);
        logic [31:0] rd;
        logic [1:0] rr;
        axi_rd(a, rd, rr);
        check(rd, d);
        check(rr, r);
    endtask
    task automatic sc_regs();
        logic [1:0] r;
        reg_chk(gcs_off_curr, gcs_rst_curr, 2'b00);
        reg_chk(gcs_off_pre, gcs_rst_pre, 2'b00);
        reg_chk(gcs_off_time, gcs_rst_time, 2'b00);
        axi_wr(gcs_off_curr, 32'h0000_c953, 4'h2, r);
        reg_chk(gcs_off_curr, 32'h0000_c900, 2'b00);
        axi_wr(8'h10, 32'hffff_ffff, 4'hf, r);
        check(r, 2'b10);
        reg_chk(8'h10, 32'h0000_0000, 2'b10);
    endtask
    task automatic cfg(input logic [31:0] cur, input logic [31:0] pre,
                       input logic [31:0] t);
        logic [1:0] r;
        axi_wr(gcs_off_curr, cur, 4'hf, r);
        axi_wr(gcs_off_pre, pre, 4'hf, r);
        axi_wr(gcs_off_time, t, 4'hf, r);
        check(r, 2'b00);
        reg_chk(gcs_off_pre, pre, 2'b00);
        {tm[3], tm[2], tm[1], tm[0]} = t;
    endtask
    // records runs of equal current selector on one channel
    task automatic capture(input int g, input logic v, input int cyc);
        logic [2:0] s;
        @(posedge aclk);
        gate_cmd[g] <= v;
        nruns = 0;
        repeat (cyc) begin
            @(posedge aclk);
            #1;
            s = gate_sel[3*g +: 3];
            if (nruns == 0 || (s !== run_sel[nruns-1] && nruns < 8)) begin
                run_sel[nruns] = s;
                run_code[nruns] = gate_code[5*g +: 5];
                run_len[nruns] = 0;
                nruns++;
            end
            run_len[nruns-1]++;
        end
    endtask
    task automatic phase(input int k, input logic [2:0] s,
                         input logic [4:0] c, input int t);
        check(run_sel[k], s);
        check(run_code[k], c);
        check(run_len[k] >= (t - 1) * gcs_tick_cyc &&
              run_len[k] <= t * gcs_tick_cyc + 1, 1'b1);
    endtask
    task automatic sc_seq(input int g, input logic v, input logic [4:0] pc,
                          input logic [4:0] sc);
        int tp;
        int ts;
        int k;
        tp = v ? tm[0] : tm[2];
        ts = v ? tm[1] : tm[3];
        capture(g, v, 120);
        k = 1;
        if (tp != 0) begin
            phase(k, gcs_sel_pre, pc, tp);
            k++;
        end
        if (ts != 0) begin
            phase(k, gcs_sel_slew, sc, ts);
            k++;
        end
        check(run_sel[k], gcs_sel_full);
        check(nruns, k + 1);
        check(run_code[k], gcs_code_max);
        check(gate_out[g], v);
    endtask
    task automatic sc_trip();
        trip_after <= 16'h0014;
        capture(4, 1'b1, 120);
        check(run_sel[nruns-1], gcs_sel_hold);
        check(run_code[nruns-1], 5'h00);
        reg_chk(gcs_off_stat, 32'h0000_0010, 2'b00);
        trip_after <= 16'hffff;
    endtask
    // comparator noise pulse of len cycles in mid transition
    task automatic sc_noise(input logic v, input int len,
                            input logic [2:0] s);
        fork
            capture(5, v, 120);
            begin
                repeat (20) @(posedge aclk);
                noise[5] <= 1'b1;
                repeat (len) @(posedge aclk);
                noise[5] <= 1'b0;
            end
        join
        check(run_sel[nruns-1], s);
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        sc_regs();
        cfg(32'h0000_c953, 32'h0000_01a7, 32'h0502_0304);
        sc_seq(0, 1'b1, 5'h07, 5'h03);
        sc_seq(1, 1'b1, 5'h07, 5'h09);
        sc_seq(0, 1'b0, 5'h0a, 5'h05);
        sc_seq(1, 1'b0, 5'h0a, 5'h0c);
        cfg(32'h0000_c953, 32'h0000_00a7, 32'h0500_0004);
        sc_seq(2, 1'b1, gcs_code_max, 5'h03);
        sc_seq(2, 1'b0, gcs_code_max, 5'h05);
        cfg(32'h0000_c953, 32'h0000_00a7, 32'h0005_0004);
        sc_seq(2, 1'b1, gcs_code_max, 5'h03);
        sc_seq(2, 1'b0, gcs_code_max, 5'h05);
        for (int c = 0; c < 16; c++) begin
            cfg(32'h0000_c953, 32'h0000_0100 | c, 32'h0502_0304);
            sc_seq(3, 1'b1, c[4:0], 5'h09);
            sc_seq(3, 1'b0, 5'h00, 5'h0c);
        end
        sc_trip();
        sc_noise(1'b1, 5, gcs_sel_full);
        sc_noise(1'b0, 12, gcs_sel_hold);
        complete_run();
    end
    initial begin
        #600000;
        fail_count++;
        complete_run();
    end
endmodule

// >>> rtl/gcs_channel.sv
/*
 sequencer for one gate driver output.
 assumes shared settings and tick from the top.
*/
`timescale 1ns/10ps
module gcs_channel
    import gcs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cmd,
    input wire logic tick,
    input wire logic cmp,
    input wire logic [3:0] slew_on,
    input wire logic [3:0] slew_off,
    input wire logic [3:0] pre_on,
    input wire logic [3:0] pre_off,
    input wire logic pre_en,
    input wire logic [7:0] t1,
    input wire logic [7:0] t2,
    input wire logic [7:0] t3,
    input wire logic [7:0] t4,
    output logic gate,
    output logic [2:0] sel,
    output logic [4:0] code
);
    gcs_state_t state, next_state;
    logic [7:0] cnt;
    logic cmd_d;
    logic trip;
    wire edge_w = cmd != cmd_d;
    wire [7:0] ta = cmd ? t1 : t3;
    wire [7:0] tb = cmd ? t2 : t4;
    wire done = tick && (cnt <= 8'h01);
    wire [4:0] pre_code = pre_en ? {1'b0, (cmd ? pre_on : pre_off)}
                                 : gcs_code_max;
    wire [4:0] slew_code = {1'b0, (cmd ? slew_on : slew_off)};
    gcs_deglitch u_degl (
        .aclk(aclk),
        .aresetn(aresetn),
        .clr(edge_w),
        .cmp(cmp),
        .trip(trip)
    );
    always_comb begin
        next_state = state;
        case (state)
            gcs_idle: next_state = state;
            gcs_pre: if (done) next_state = (tb != 8'h00) ? gcs_slew : gcs_full;
            gcs_slew: if (done) next_state = gcs_full;
            gcs_full: next_state = state;
            gcs_hold: next_state = state;
            default: next_state = gcs_idle;
        endcase
        if (edge_w) begin
            if (ta != 8'h00) next_state = gcs_pre;
            else if (tb != 8'h00) next_state = gcs_slew;
            else next_state = gcs_full;
        end else if (trip && state != gcs_idle) begin
            next_state = gcs_hold;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= gcs_idle;
            cnt <= 8'h00;
            cmd_d <= 1'b0;
            gate <= 1'b0;
            sel <= gcs_sel_none;
            code <= 5'h00;
        end else begin
            cmd_d <= cmd;
            gate <= cmd;
            state <= next_state;
            if (next_state == gcs_pre && state != gcs_pre) cnt <= ta;
            else if (next_state == gcs_slew && state != gcs_slew) cnt <= tb;
            else if (tick && cnt != 8'h00) cnt <= cnt - 8'h01;
            case (next_state)
                gcs_pre: begin
                    sel <= gcs_sel_pre;
                    code <= pre_code;
                end
                gcs_slew: begin
                    sel <= gcs_sel_slew;
                    code <= slew_code;
                end
                gcs_full: begin
                    sel <= gcs_sel_full;
                    code <= gcs_code_max;
                end
                gcs_hold: begin
                    sel <= gcs_sel_hold;
                    code <= 5'h00;
                end
                default: begin
                    sel <= gcs_sel_none;
                    code <= 5'h00;
                end
            endcase
        end
    end
    sequence s_trip_seen;
        trip && !edge_w && state != gcs_idle;
    endsequence
    property p_hold;
        @(posedge aclk) disable iff (!aresetn)
        s_trip_seen |=> sel == gcs_sel_hold;
    endproperty
    a_hold: assert property (p_hold) else $error("trip not holding");
    property p_skip;
        @(posedge aclk) disable iff (!aresetn)
        edge_w && ta == 8'h00 && tb == 8'h00 |=> sel == gcs_sel_full;
    endproperty
    a_skip: assert property (p_skip) else $error("zero times not skipped");
    property p_pre;
        @(posedge aclk) disable iff (!aresetn)
        edge_w && ta != 8'h00 |=> sel == gcs_sel_pre;
    endproperty
    a_pre: assert property (p_pre) else $error("no pre phase");
    property p_max;
        @(posedge aclk) disable iff (!aresetn)
        sel == gcs_sel_pre && !$past(pre_en) |-> code == gcs_code_max;
    endproperty
    a_max: assert property (p_max) else $error("pre not max");
    property p_full;
        @(posedge aclk) disable iff (!aresetn)
        state == gcs_slew && next_state == gcs_full && !edge_w |=>
        sel == gcs_sel_full;
    endproperty
    a_full: assert property (p_full) else $error("no full after slew");
endmodule

// >>> rtl/gcs_deglitch.sv
/*
 deglitch filter for one gate-source comparator.
 assumes cmp is synchronous to aclk.
*/
`timescale 1ns/10ps
module gcs_deglitch
    import gcs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clr,
    input wire logic cmp,
    output logic trip
);
    logic [3:0] cnt;
    localparam logic [3:0] lim = 4'(gcs_degl_cyc);
    always_ff @(posedge aclk) begin
        if (!aresetn || clr || !cmp) begin
            cnt <= 4'h0;
            trip <= 1'b0;
        end else if (cnt == lim) begin
            trip <= 1'b1;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
    property p_degl;
        @(posedge aclk) disable iff (!aresetn)
        $rose(trip) |-> $past(cmp, 1) && $past(cmp, 6) && $past(cmp, 11);
    endproperty
    a_degl: assert property (p_degl) else $error("trip without cmp");
endmodule

// >>> rtl/gcs_pkg.sv
/*
 package of constants for the gate current sequencer.
 assumes a 50 MHz aclk and an AXI4-Lite master that configures it.
*/
// Function
// - turn-on begins with pre-charge current for the pre-charge time
// - then side-specific turn-on current for the turn-on slew time
// - then full 1.5 A current for the rest of the transition
// - turn-off mirrors: pre-discharge, side sink current, then full sink
// - slew currents per side; pre currents shared by both sides
// - pre-current enable clear selects maximum current for pre phases
// - pre current has 17 choices: 16 codes plus maximum
// - a drive time of zero skips its phase
// - comparator trip forces hold current in any phase
// - comparator trip is deglitched for a fixed time first
// - one configuration set serves all six drivers
package gcs_pkg;
    localparam int gcs_clk_mhz = 50;
    localparam int gcs_tick_ns = 100;
    localparam int gcs_tick_cyc = (gcs_tick_ns * gcs_clk_mhz + 999) / 1000;
    localparam int gcs_degl_ns = 200;
    localparam int gcs_degl_cyc = (gcs_degl_ns * gcs_clk_mhz + 999) / 1000;
    localparam logic [7:0] gcs_off_curr = 8'h00;
    localparam logic [7:0] gcs_off_pre = 8'h04;
    localparam logic [7:0] gcs_off_time = 8'h08;
    localparam logic [7:0] gcs_off_stat = 8'h0c;
    localparam logic [31:0] gcs_rst_curr = 32'h0000_0000;
    localparam logic [31:0] gcs_rst_pre = 32'h0000_0000;
    localparam logic [31:0] gcs_rst_time = 32'h0000_0000;
    localparam int gcs_pre_en_bit = 8;
    // current selector codes on the gate current output
    localparam logic [2:0] gcs_sel_none = 3'h0;
    localparam logic [2:0] gcs_sel_pre = 3'h1;
    localparam logic [2:0] gcs_sel_slew = 3'h2;
    localparam logic [2:0] gcs_sel_full = 3'h3;
    localparam logic [2:0] gcs_sel_hold = 3'h4;
    localparam logic [4:0] gcs_code_max = 5'h10;
    typedef enum logic [2:0] {
        gcs_idle = 3'b000,
        gcs_pre = 3'b001,
        gcs_slew = 3'b010,
        gcs_full = 3'b011,
        gcs_hold = 3'b100
    } gcs_state_t;
endpackage

// >>> rtl/gcs_top.sv
/*
 gate current sequencer top: AXI4-Lite settings and six channels.
 assumes one aclk domain and synchronous command and comparator inputs.
*/
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
module gcs_top
    import gcs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [5:0] gate_cmd,
    input wire logic [5:0] vgs_cmp,
    output logic [5:0] gate_out,
    output logic [17:0] gate_sel,
    output logic [29:0] gate_code
);
    // curr: hs_on[3:0] hs_off[7:4] ls_on[11:8] ls_off[15:12]
    // pre: pre_on[3:0] pre_off[7:4] pre_en[8]; time: t1..t4 bytes
    logic [31:0] curr_reg, pre_reg, time_reg;
    logic [7:0] aw_a;
    logic aw_h, w_h;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic [7:0] tcnt;
    logic tick;
    logic [5:0] gate_w;
    logic [17:0] sel_w;
    logic [29:0] code_w;
    function automatic logic [31:0] wmerge(input logic [31:0] o,
                                           input logic [31:0] d,
                                           input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
        end
        return r;
    endfunction
    wire do_w = aw_h && w_h && !s_axi_bvalid;
    wire w_ok = aw_a == gcs_off_curr || aw_a == gcs_off_pre ||
                aw_a == gcs_off_time;
    wire w_ok_r = s_axi_araddr == gcs_off_curr ||
                  s_axi_araddr == gcs_off_pre || s_axi_araddr == gcs_off_time;
    wire r_ok = w_ok_r || s_axi_araddr == gcs_off_stat;
    wire [31:0] stat_w = {26'h000_0000, gate_w};
    wire [31:0] rd_w = s_axi_araddr == gcs_off_curr ? curr_reg :
                       s_axi_araddr == gcs_off_pre ? pre_reg :
                       s_axi_araddr == gcs_off_time ? time_reg :
                       s_axi_araddr == gcs_off_stat ? stat_w : 32'h0000_0000;
    wire do_r = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_h <= 1'b0;
            w_h <= 1'b0;
            aw_a <= 8'h00;
            w_d <= 32'h0000_0000;
            w_s <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            curr_reg <= gcs_rst_curr;
            pre_reg <= gcs_rst_pre;
            time_reg <= gcs_rst_time;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_a <= s_axi_awaddr;
                aw_h <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_d <= s_axi_wdata;
                w_s <= s_axi_wstrb;
                w_h <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_w) begin
                if (aw_a == gcs_off_curr) curr_reg <= wmerge(curr_reg, w_d, w_s);
                if (aw_a == gcs_off_pre) pre_reg <= wmerge(pre_reg, w_d, w_s);
                if (aw_a == gcs_off_time) time_reg <= wmerge(time_reg, w_d, w_s);
                s_axi_bresp <= w_ok ? 2'b00 : 2'b10;
                s_axi_bvalid <= 1'b1;
                aw_h <= 1'b0;
                w_h <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (do_r) begin
            s_axi_rdata <= rd_w;
            s_axi_rresp <= r_ok ? 2'b00 : 2'b10;
            s_axi_rvalid <= 1'b1;
            s_axi_arready <= 1'b0;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
    // time base for drive-time counting
    always_ff @(posedge aclk) begin
        if (!aresetn || tick) begin
            tcnt <= 8'h00;
        end else begin
            tcnt <= tcnt + 8'h01;
        end
    end
    assign tick = tcnt == 8'(gcs_tick_cyc - 1);
    for (genvar g = 0; g < 6; g++) begin : ch
        // even channels high side, odd low side
        localparam int sb = (g % 2) * 8;
        gcs_channel u_ch (
            .aclk(aclk),
            .aresetn(aresetn),
            .cmd(gate_cmd[g]),
            .tick(tick),
            .cmp(vgs_cmp[g]),
            .slew_on(curr_reg[sb +: 4]),
            .slew_off(curr_reg[sb + 4 +: 4]),
            .pre_on(pre_reg[3:0]),
            .pre_off(pre_reg[7:4]),
            .pre_en(pre_reg[gcs_pre_en_bit]),
            .t1(time_reg[7:0]),
            .t2(time_reg[15:8]),
            .t3(time_reg[23:16]),
            .t4(time_reg[31:24]),
            .gate(gate_w[g]),
            .sel(sel_w[g*3 +: 3]),
            .code(code_w[g*5 +: 5])
        );
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate_out <= 6'h00;
            gate_sel <= 18'h0_0000;
            gate_code <= 30'h0000_0000;
        end else begin
            gate_out <= gate_w;
            gate_sel <= sel_w;
            gate_code <= code_w;
        end
    end
    property p_bresp;
        @(posedge aclk) disable iff (!aresetn)
        do_w |=> s_axi_bvalid;
    endproperty
    a_bresp: assert property (p_bresp) else $error("no write response");
    property p_tick;
        @(posedge aclk) disable iff (!aresetn)
        tick |=> !tick;
    endproperty
    a_tick: assert property (p_tick) else $error("tick too long");
    property p_pipe;
        @(posedge aclk) disable iff (!aresetn)
        gate_sel == $past(sel_w);
    endproperty
    a_pipe: assert property (p_pipe) else $error("sel not registered");
endmodule
